// ---- verilog/sld_pkg.sv ----
// Constants shared by the segment LCD drive controller and its frame timer.
// Assumes a 200 MHz system clock and an AXI4-Lite master reaching the registers.
//
// Behaviour
// RL1: Frame timing signal is driven onto frame_monitor_out.
// RL2: Ext select 0 with regulator and booster on means internal generation.
// RL3: Bias choice 0 gives one-fifth bias, 1 gives one-quarter bias.
// RL4: Ext select 1 with regulator and booster off means external voltage.
// RL5: Heavy-load bit 1 puts regulator into heavy-load protection.
// RL6: Two-bit booster clock field selects the booster clock rate.
// RL7: Four-bit contrast picks one of 16 levels, ignored in external mode.
// RL8: Software initialises clocks, enable, timing, power, display, RAM in order.
// RL9: Module enable 1 lets the operating clock reach the driver logic.
// RL10: Pin discharge 1 discharges driver pins while display is off.
// RL11: Writing 1 to the frame flag clears it.
// RL12: Frame interrupt enable lets the flag raise an interrupt request.
// RL13: Display control 3 all off, 2 all on, 1 normal, 0 off.
// RL14: Display off stops drive supply and grounds all driver outputs.
// RL15: All-on and all-off change only the waveform, never display RAM.
// RL16: All-on keeps multiplexed commons; all-off makes commons static.
// RL17: Invert bit 0 inverts every segment, 1 gives normal polarity.
// RL18: No inversion while all-off is selected.
// RL19: Frame lasts 8 x (divider+1) x (duty+1) operating clocks.
// RL20: Duty code 0x1F is 1/32 duty down to static at 0x00.
// RL21: Inverse-line count 0 is normal, else polarity flips every n lines.
// RL22: Frame flag is set once per frame.
// RL23: Display control, invert and duty changes apply at frame boundaries.

package sld_pkg;
   // ==========================================================
   // Timing
   localparam int unsigned CLK_HZ     = 200_000_000;
   localparam int unsigned OPCLK_HZ   = 32_768;
   localparam int unsigned OPCLK_DIV  = CLK_HZ / OPCLK_HZ;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_CTL     = 8'h00;
   localparam logic [7:0] OFF_TIM1    = 8'h04;
   localparam logic [7:0] OFF_TIM2    = 8'h08;
   localparam logic [7:0] OFF_PWR     = 8'h0C;
   localparam logic [7:0] OFF_DSP     = 8'h10;
   localparam logic [7:0] OFF_INTF    = 8'h14;
   localparam logic [7:0] OFF_INTE    = 8'h18;
   localparam logic [7:0] OFF_CLK     = 8'h1C;

   // ==========================================================
   // Writable bits per register, indexed by word
   localparam logic [31:0] REG_MASK [0:7] = '{
      32'h0000_0003, 32'h0000_1F1F, 32'h0000_031F, 32'h0000_0F1F,
      32'h0000_0713, 32'h0000_0001, 32'h0000_0001, 32'h0000_0073};
   localparam logic [31:0] RST_DSP    = 32'h0000_0010;

   // ==========================================================
   // Field positions
   localparam int CTL_EN      = 0;
   localparam int CTL_DIS     = 1;
   localparam int TIM1_DUTY   = 0;
   localparam int TIM1_FRM    = 8;
   localparam int TIM2_INVERSE_LINE_COUNT  = 0;
   localparam int TIM2_BOOSTER_CLOCK_RATE   = 8;
   localparam int PWR_REGULATOR_ENABLE    = 0;
   localparam int PWR_BOOSTER_ENABLE   = 1;
   localparam int PWR_EXVC    = 2;
   localparam int PWR_BIAS    = 3;
   localparam int PWR_HEAVY_LOAD_PROTECT    = 4;
   localparam int PWR_LC      = 8;
   localparam int DSP_CTRL    = 0;
   localparam int DSP_INV     = 4;
   localparam int DSP_AREA    = 8;
   localparam int DSP_COMMON_ORDER_REVERSE  = 9;
   localparam int DSP_SEGMENT_ORDER_REVERSE  = 10;
   localparam int CLK_SRC     = 0;
   localparam int CLK_DIV     = 4;

   // ==========================================================
   // Display control codes and bus answers
   localparam logic [1:0] DISPLAY_CONTROL_OFF    = 2'h0;
   localparam logic [1:0] DISPLAY_CONTROL_NORM   = 2'h1;
   localparam logic [1:0] DISPLAY_CONTROL_ALLON  = 2'h2;
   localparam logic [1:0] DISPLAY_CONTROL_ALLOFF = 2'h3;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- verilog/sld_frame_timer.sv ----
// Frame timer: operating-clock tick, line and frame pulses.
// Assumes run, duty and divider come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module sld_frame_timer
   import sld_pkg::*;
#(
   parameter int unsigned PRESCALE = OPCLK_DIV
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic [4:0] duty,
   input  wire logic [4:0] frm_div,
   output logic            line_pulse,
   output logic            frame_pulse,
   output logic [4:0]      line_idx
);
   typedef struct packed {
      logic [15:0] pre;
      logic [7:0]  tick;
      logic [4:0]  line;
      logic        lp;
      logic        fp;
   } sld_tmr_s;

   sld_tmr_s s_r;
   sld_tmr_s s_nxt;

   // Last tick of a line: 8 x (divider+1) - 1
   function automatic logic [7:0] line_last(input logic [4:0] f);
      return {f, 3'h7};
   endfunction

   // ==========================================================
   // Counters
   always_comb begin
      s_nxt    = s_r;
      s_nxt.lp = 1'b0;
      s_nxt.fp = 1'b0;
      // RL9: clock gate
      if (!run) begin
         s_nxt.pre  = '0;
         s_nxt.tick = '0;
         s_nxt.line = '0;
      end else if (s_r.pre == 16'(PRESCALE - 1)) begin
         s_nxt.pre = '0;
         // RL19: line and frame length
         if (s_r.tick == line_last(frm_div)) begin
            s_nxt.tick = '0;
            s_nxt.lp   = 1'b1;
            // RL20: duty+1 lines per frame
            if (s_r.line >= duty) begin
               s_nxt.line = '0;
               s_nxt.fp   = 1'b1;
            end else begin
               s_nxt.line = s_r.line + 5'h01;
            end
         end else begin
            s_nxt.tick = s_r.tick + 8'h01;
         end
      end else begin
         s_nxt.pre = s_r.pre + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign line_pulse  = s_r.lp;
   assign frame_pulse = s_r.fp;
   assign line_idx    = s_r.line;

   // ==========================================================
   // Checks
   sequence q_frame_end;
      frame_pulse && line_pulse;
   endsequence

   a_frame_spacing: assert property (@(posedge clk) disable iff (!rst_n) // RL19
      q_frame_end |=> !frame_pulse [*7])
      else $error("frame pulses closer than one line");

   a_run_gate: assert property (@(posedge clk) disable iff (!rst_n) // RL9
      !run |=> !frame_pulse && line_idx == 5'h00)
      else $error("timer advanced while disabled");
endmodule

`default_nettype wire

// ---- verilog/sld_lcd_ctrl.sv ----
// Segment LCD drive controller: AXI4-Lite registers, power and display
// decode, frame-boundary updates, AC inversion and frame interrupt.
// Assumes a single 200 MHz clock; panel drivers sit outside.
`timescale 1ns/100ps
`default_nettype none

module sld_lcd_ctrl
   import sld_pkg::*;
#(
   parameter int unsigned PRESCALE = OPCLK_DIV
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Panel side
   output logic             frame_monitor_out,
   output logic             internal_mode,
   output logic             ext_mode,
   output logic             regulator_on,
   output logic             booster_on,
   output logic             bias_quarter,
   output logic             heavy_load_on,
   output logic [1:0]       booster_clock_sel,
   output logic [3:0]       contrast_out,
   output logic             drive_supply_on,
   output logic [1:0]       display_mode,
   output logic             com_static,
   output logic             seg_invert,
   output logic             pins_discharge,
   output logic             ac_polarity,
   output logic [4:0]       com_line,
   output logic             area_sel,
   output logic             com_reverse,
   output logic             seg_reverse,
   output logic [1:0]       clock_source_select,
   output logic [2:0]       clock_divider_select,
   output logic             frame_irq
);
   typedef struct packed {
      logic [7:0][31:0] regs;
      logic             aw_got;
      logic [7:0]       aw_addr;
      logic             w_got;
      logic [31:0]      wdata;
      logic [3:0]       wstrb;
      logic             awready;
      logic             wready;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             arready;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
      logic [1:0]       act_display_control;
      logic             act_inv;
      logic [4:0]       act_duty;
      logic [4:0]       inv_cnt;
      logic             ac_pol;
      logic             fmon;
      logic             int_mode;
      logic             ext_mode;
      logic             reg_on;
      logic             bst_on;
      logic             bias4;
      logic             heavy_load_protect;
      logic [1:0]       booster_clock_rate;
      logic [3:0]       lc;
      logic             supply;
      logic [1:0]       dmode;
      logic             cstat;
      logic             sinv;
      logic             disch;
      logic [4:0]       cline;
      logic [2:0]       dsp_map;
      logic [4:0]       clk_sel;
      logic             irq;
   } sld_ctrl_s;

   sld_ctrl_s s_r;
   sld_ctrl_s s_nxt;
   logic      line_p;
   logic      frame_p;
   logic [4:0] line_i;

   // Only the first eight words are mapped
   function automatic logic mapped(input logic [7:0] a);
      return a[7:5] == 3'h0;
   endfunction

   // Byte-lane merge, limited to writable bits
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  be,
                                         input logic [31:0] m);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) r[8*b +: 8] = d[8*b +: 8];
      end
      return r & m;
   endfunction

   // ==========================================================
   // Field views of the current registers
   logic [31:0] ctl_w, tim1_w, tim2_w, pwr_w, dsp_w;
   logic        mod_en;
   assign ctl_w  = s_r.regs[OFF_CTL[4:2]];
   assign tim1_w = s_r.regs[OFF_TIM1[4:2]];
   assign tim2_w = s_r.regs[OFF_TIM2[4:2]];
   assign pwr_w  = s_r.regs[OFF_PWR[4:2]];
   assign dsp_w  = s_r.regs[OFF_DSP[4:2]];
   assign mod_en = ctl_w[CTL_EN];

   // RL9: timer runs only with module enable
   sld_frame_timer #(
      .PRESCALE (PRESCALE)
   ) u_timer (
      .clk         (clk),
      .rst_n       (rst_n),
      .run         (mod_en),
      .duty        (s_r.act_duty),
      .frm_div     (tim1_w[TIM1_FRM +: 5]),
      .line_pulse  (line_p),
      .frame_pulse (frame_p),
      .line_idx    (line_i)
   );

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic [2:0] wi;
      logic       bound;
      logic [4:0] nl;
      s_nxt = s_r;
      wi    = s_r.aw_addr[4:2];
      bound = frame_p || !mod_en;
      nl    = tim2_w[TIM2_INVERSE_LINE_COUNT +: 5];

      // Address and data are taken independently
      if (s_axi_awvalid && s_r.awready) begin
         s_nxt.aw_got  = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_r.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready) s_nxt.bvalid = 1'b0;
      if (s_nxt.aw_got && s_nxt.w_got && !s_nxt.bvalid) begin
         wi            = s_nxt.aw_addr[4:2];
         s_nxt.aw_got  = 1'b0;
         s_nxt.w_got   = 1'b0;
         s_nxt.bvalid  = 1'b1;
         s_nxt.bresp   = mapped(s_nxt.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         if (!mapped(s_nxt.aw_addr)) begin
            s_nxt.bresp = RESP_SLVERR;
         end else if (wi == OFF_INTF[4:2]) begin
            // RL11: write one to clear
            if (s_nxt.wstrb[0] && s_nxt.wdata[0]) s_nxt.regs[wi][0] = 1'b0;
         end else begin
            s_nxt.regs[wi] = merge(s_r.regs[wi], s_nxt.wdata, s_nxt.wstrb,
                                   REG_MASK[wi]);
         end
      end
      s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
      s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;

      // RL22: frame sets the flag; set beats a clear
      if (frame_p) s_nxt.regs[OFF_INTF[4:2]][0] = 1'b1;

      // Reads answer one cycle after the address is taken
      if (s_r.rvalid && s_axi_rready) s_nxt.rvalid = 1'b0;
      if (s_axi_arvalid && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         s_nxt.rdata  = mapped(s_axi_araddr) ?
                        s_r.regs[s_axi_araddr[4:2]] & REG_MASK[s_axi_araddr[4:2]] :
                        32'h0000_0000;
      end
      s_nxt.arready = !s_nxt.rvalid;

      // RL23: display settings latched at frame boundary
      if (bound) begin
         s_nxt.act_display_control = dsp_w[DSP_CTRL +: 2];
         s_nxt.act_inv  = dsp_w[DSP_INV];
         s_nxt.act_duty = tim1_w[TIM1_DUTY +: 5];
      end

      // RL1: monitor toggles each frame
      s_nxt.fmon = mod_en && (frame_p ? !s_r.fmon : s_r.fmon);

      // RL21: polarity flips every n lines, else every frame
      if (!mod_en) begin
         s_nxt.inv_cnt = '0;
         s_nxt.ac_pol  = 1'b0;
      end else if (nl == 5'h00) begin
         s_nxt.inv_cnt = '0;
         if (frame_p) s_nxt.ac_pol = !s_r.ac_pol;
      end else if (line_p) begin
         if (s_r.inv_cnt + 5'h01 >= nl) begin
            s_nxt.inv_cnt = '0;
            s_nxt.ac_pol  = !s_r.ac_pol;
         end else begin
            s_nxt.inv_cnt = s_r.inv_cnt + 5'h01;
         end
      end

      // RL2: internal generation
      s_nxt.int_mode = !pwr_w[PWR_EXVC] && pwr_w[PWR_REGULATOR_ENABLE] && pwr_w[PWR_BOOSTER_ENABLE];
      // RL4: external voltage application
      s_nxt.ext_mode = pwr_w[PWR_EXVC] && !pwr_w[PWR_REGULATOR_ENABLE] && !pwr_w[PWR_BOOSTER_ENABLE];
      // RL14: supply stops while display off
      s_nxt.supply   = mod_en && s_r.act_display_control != DISPLAY_CONTROL_OFF;
      s_nxt.reg_on   = s_nxt.supply && pwr_w[PWR_REGULATOR_ENABLE];
      s_nxt.bst_on   = s_nxt.supply && pwr_w[PWR_BOOSTER_ENABLE];
      // RL3: bias choice
      s_nxt.bias4    = pwr_w[PWR_BIAS];
      // RL5: heavy-load protection
      s_nxt.heavy_load_protect     = pwr_w[PWR_HEAVY_LOAD_PROTECT];
      // RL6: booster clock rate
      s_nxt.booster_clock_rate     = tim2_w[TIM2_BOOSTER_CLOCK_RATE +: 2];
      // RL7: contrast has no effect with external supply
      s_nxt.lc       = pwr_w[PWR_EXVC] ? 4'h0 : pwr_w[PWR_LC +: 4];
      // RL13: waveform selection; RL15: RAM never touched here
      s_nxt.dmode    = s_r.act_display_control;
      // RL16: all-off and static duty use static commons
      s_nxt.cstat    = s_r.act_display_control == DISPLAY_CONTROL_ALLOFF || s_r.act_duty == 5'h00;
      // RL17: invert bit 0 inverts; RL18: never under all-off
      s_nxt.sinv     = !s_r.act_inv && s_r.act_display_control != DISPLAY_CONTROL_ALLOFF &&
                       s_r.act_display_control != DISPLAY_CONTROL_OFF;
      // RL10: discharge only while display off
      s_nxt.disch    = ctl_w[CTL_DIS] && s_r.act_display_control == DISPLAY_CONTROL_OFF;
      s_nxt.cline    = line_i;
      s_nxt.dsp_map  = {dsp_w[DSP_SEGMENT_ORDER_REVERSE], dsp_w[DSP_COMMON_ORDER_REVERSE], dsp_w[DSP_AREA]};
      s_nxt.clk_sel  = {s_r.regs[OFF_CLK[4:2]][CLK_DIV +: 3],
                        s_r.regs[OFF_CLK[4:2]][CLK_SRC +: 2]};
      // RL12: enable gates flag onto request
      s_nxt.irq      = s_r.regs[OFF_INTF[4:2]][0] && s_r.regs[OFF_INTE[4:2]][0];
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r                    <= '0;
         s_r.regs[OFF_DSP[4:2]] <= RST_DSP;
         s_r.act_inv            <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign s_axi_awready        = s_r.awready;
   assign s_axi_wready         = s_r.wready;
   assign s_axi_bvalid         = s_r.bvalid;
   assign s_axi_bresp          = s_r.bresp;
   assign s_axi_arready        = s_r.arready;
   assign s_axi_rvalid         = s_r.rvalid;
   assign s_axi_rdata          = s_r.rdata;
   assign s_axi_rresp          = s_r.rresp;
   assign frame_monitor_out    = s_r.fmon;
   assign internal_mode        = s_r.int_mode;
   assign ext_mode             = s_r.ext_mode;
   assign regulator_on         = s_r.reg_on;
   assign booster_on           = s_r.bst_on;
   assign bias_quarter         = s_r.bias4;
   assign heavy_load_on        = s_r.heavy_load_protect;
   assign booster_clock_sel    = s_r.booster_clock_rate;
   assign contrast_out         = s_r.lc;
   assign drive_supply_on      = s_r.supply;
   assign display_mode         = s_r.dmode;
   assign com_static           = s_r.cstat;
   assign seg_invert           = s_r.sinv;
   assign pins_discharge       = s_r.disch;
   assign ac_polarity          = s_r.ac_pol;
   assign com_line             = s_r.cline;
   assign area_sel             = s_r.dsp_map[0];
   assign com_reverse          = s_r.dsp_map[1];
   assign seg_reverse          = s_r.dsp_map[2];
   assign clock_source_select  = s_r.clk_sel[1:0];
   assign clock_divider_select = s_r.clk_sel[4:2];
   assign frame_irq            = s_r.irq;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_frame_monitor: assert property (frame_p && mod_en |=> $changed(frame_monitor_out)) // RL1
      else $error("monitor did not follow frame");
   a_internal_mode: assert property (1 |=> internal_mode == // RL2
      $past(!pwr_w[PWR_EXVC] && pwr_w[PWR_REGULATOR_ENABLE] && pwr_w[PWR_BOOSTER_ENABLE]))
      else $error("internal mode decode wrong");
   a_bias_select: assert property (1 |=> bias_quarter == $past(pwr_w[PWR_BIAS])) // RL3
      else $error("bias wrong");
   a_ext_mode: assert property (ext_mode |-> !regulator_on && !booster_on) // RL4
      else $error("external mode with supplies on");
   a_heavy_load: assert property (1 |=> heavy_load_on == $past(pwr_w[PWR_HEAVY_LOAD_PROTECT])) // RL5
      else $error("heavy load wrong");
   a_boost_clock: assert property (1 |=> booster_clock_sel == $past(tim2_w[9:8])) // RL6
      else $error("booster clock wrong");
   a_contrast_ext: assert property ($past(pwr_w[PWR_EXVC]) |-> contrast_out == 4'h0) // RL7
      else $error("contrast applied in external mode");
   a_discharge: assert property (pins_discharge |-> $past(s_r.act_display_control) == DISPLAY_CONTROL_OFF) // RL10
      else $error("discharge while display on");
   a_flag_clear: assert property (s_axi_bvalid && !$past(s_axi_bvalid) && // RL11
      s_r.aw_addr == OFF_INTF && s_r.wdata[0] && s_r.wstrb[0]
      && !$past(frame_p) |-> !s_r.regs[5][0])
      else $error("flag not cleared");
   a_irq_gate: assert property (frame_irq |-> $past(s_r.regs[6][0])) // RL12
      else $error("irq without enable");
   a_display_off: assert property (s_r.act_display_control == DISPLAY_CONTROL_OFF |=> !drive_supply_on) // RL14
      else $error("supply on while display off");
   a_alloff_static: assert property (s_r.act_display_control == DISPLAY_CONTROL_ALLOFF // RL16
      |=> com_static && !seg_invert)
      else $error("all-off not static or inverted");
   a_flag_set: assert property (frame_p |=> s_r.regs[5][0]) // RL22
      else $error("frame flag not set");
   a_frame_bound: assert property ($changed(s_r.act_display_control) // RL23
      |-> $past(frame_p || !mod_en))
      else $error("display changed mid-frame");
   a_ac_invert: assert property (mod_en && (tim2_w[TIM2_INVERSE_LINE_COUNT +: 5] == 5'h01 ? // RL21
      line_p : frame_p && tim2_w[TIM2_INVERSE_LINE_COUNT +: 5] == 5'h00) |=> $changed(ac_polarity))
      else $error("polarity did not flip");
endmodule

`default_nettype wire

// ---- testbench/sld_panel_model.sv ----
// Passive panel stand-in: times the spacing of frame monitor toggles.
// Assumes the controller's clock and reset.
`timescale 1ns/100ps
`default_nettype none
module sld_panel_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        frame_monitor_out,
   output logic      [15:0] period
);
   logic        mon_r;
   logic [15:0] cnt_r;
   // ====
   // toggle spacing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mon_r <= 1'b0;
         cnt_r <= 16'h0000;
         period <= 16'h0000;
      end else begin
         mon_r <= frame_monitor_out;
         cnt_r <= (mon_r != frame_monitor_out) ? 16'h0001 : cnt_r + 16'h0001;
         if (mon_r != frame_monitor_out) period <= cnt_r;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Bench for the segment LCD controller: bus, power, display, frames.
// Assumes a short PRESCALE so that frames last 32 to 128 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import sld_pkg::*;
   localparam int PS = 2;
   logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, frame_monitor_out, internal_mode, ext_mode, regulator_on;
   logic        booster_on, bias_quarter, heavy_load_on, drive_supply_on, com_static;
   logic        seg_invert, pins_discharge, ac_polarity, area_sel, com_reverse;
   logic        seg_reverse, frame_irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot, clock_divider_select;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, contrast_out;
   logic [1:0]  s_axi_bresp, s_axi_rresp, booster_clock_sel, display_mode, clock_source_select;
   logic [4:0]  com_line;
   logic [15:0] period;
   int          failures, total_checks;
   sld_lcd_ctrl #(.PRESCALE(PS)) uut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .frame_monitor_out, .internal_mode, .ext_mode,
      .regulator_on, .booster_on, .bias_quarter, .heavy_load_on, .booster_clock_sel,
      .contrast_out, .drive_supply_on, .display_mode, .com_static, .seg_invert,
      .pins_discharge, .ac_polarity, .com_line, .area_sel, .com_reverse, .seg_reverse,
      .clock_source_select, .clock_divider_select, .frame_irq);
   sld_panel_model pnl (.clk, .rst_n, .frame_monitor_out, .period);
   // ====
   // Clock, compare and closing
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic tmo();
      failures++;
      $display("[ERR] wait expected done seen timeout");
      report_and_stop();
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // ====
   // Bus cycles: payload held until each channel's ready
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 64; n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            chk("bresp", 32'(er), 32'(s_axi_bresp));
            return;
         end
      end
      tmo();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 64; n++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            chk("rdata", ed, s_axi_rdata);
            chk("rresp", 32'(er), 32'(s_axi_rresp));
            return;
         end
      end
      tmo();
   endtask
   // ====
   // Scenarios, in the order software must set the block up
   task automatic s_init();
      rd(OFF_DSP, RST_DSP, RESP_OKAY);
      wr(OFF_CLK, 32'h0000_0021, RESP_OKAY);
      wr(OFF_CTL, 32'h0000_0003, RESP_OKAY);
      wr(OFF_TIM1, 32'h0000_0001, RESP_OKAY);
      wr(OFF_TIM2, 32'h0000_0200, RESP_OKAY);
      cyc(3);
      chk("clk sel", 32'h0A, 32'({clock_source_select, clock_divider_select}));
      chk("boost clk", 32'h2, 32'(booster_clock_sel));
   endtask
   task automatic s_power();
      logic [31:0] pw [2] = '{32'h0000_051C, 32'h0000_0A03};
      logic [7:0]  ex [2] = '{8'h70, 8'h8A};
      for (int i = 0; i < 2; i++) begin
         wr(OFF_PWR, pw[i], RESP_OKAY);
         cyc(3);
         chk("power", 32'(ex[i]), 32'({internal_mode, ext_mode, bias_quarter,
            heavy_load_on, contrast_out}));
      end
   endtask
   task automatic s_disp();
      logic [10:0] e;
      logic [1:0] m;
      for (int i = 0; i < 8; i++) begin
         m = i[1:0];
         e = {m, {3{m != DISPLAY_CONTROL_OFF}}, m == DISPLAY_CONTROL_ALLOFF, !i[2] && m[1] != m[0], m == DISPLAY_CONTROL_OFF,
              {3{i[2]}}};
         wr(OFF_DSP, {21'h0, {3{i[2]}}, 3'h0, i[2], 2'b00, m}, RESP_OKAY);
         cyc(80);
         chk("display", 32'(e), 32'({display_mode, drive_supply_on, regulator_on,
            booster_on, com_static, seg_invert, pins_discharge, area_sel, com_reverse,
            seg_reverse}));
      end
   endtask
   task automatic s_frame();
      logic [31:0] t [2] = '{32'h0000_0001, 32'h0000_0103};
      int f;
      for (int i = 0; i < 2; i++) begin
         f = PS * 8 * (int'(t[i][12:8]) + 1) * (int'(t[i][4:0]) + 1);
         wr(OFF_TIM1, t[i], RESP_OKAY);
         cyc(3 * f + 10);
         chk("frame period", 32'(f), 32'(period));
      end
   endtask
   task automatic s_irq();
      int n;
      wr(OFF_TIM2, 32'h0000_0201, RESP_OKAY);
      wr(OFF_INTF, 32'h1, RESP_OKAY);
      wr(OFF_INTE, 32'h1, RESP_OKAY);
      for (n = 0; n < 300 && frame_irq !== 1'b1; n++) @(posedge clk);
      if (n == 300) tmo();
      rd(OFF_INTF, 32'h1, RESP_OKAY);
      wr(OFF_INTF, 32'h1, RESP_OKAY);
      cyc(2);
      chk("irq clear", 32'h0, 32'(frame_irq));
      wr(OFF_INTE, 32'h0, RESP_OKAY);
      cyc(140);
      chk("irq masked", 32'h0, 32'(frame_irq));
      rd(OFF_INTF, 32'h1, RESP_OKAY);
   endtask
   // Unmapped places answer an error and leave the map alone
   task automatic s_bad();
      rd(8'h20, 32'h0, RESP_SLVERR);
      wr(8'h24, 32'hFFFF_FFFF, RESP_SLVERR);
      rd(OFF_TIM1, 32'h0000_0103, RESP_OKAY);
   endtask
   initial begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      failures = 0;
      total_checks = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      s_init();
      s_power();
      s_disp();
      s_frame();
      s_irq();
      s_bad();
      report_and_stop();
   end
endmodule
`default_nettype wire
